// ---- hdl/sbic_pkg.sv ----
/*
 * shared types and constants for the serial break and idle control block.
 * assumes a single clock domain and plain control ports, no register bus.
 */
package sbic_pkg;
    // ------------------------------------------------------------
    // frame shape
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 9;
    localparam int unsigned FRAME_W = 11;
    localparam logic [3:0] FRAME_LEN_SHORT = 4'ha;
    localparam logic [3:0] FRAME_LEN_LONG = 4'hb;
    localparam logic [3:0] DATA_LEN_SHORT = 4'h8;
    localparam logic [3:0] DATA_LEN_LONG = 4'h9;
    localparam logic LINE_IDLE = 1'b1;
    localparam int unsigned BIT_CYCLES_DEF = 16;
    localparam int unsigned FIFO_DEPTH_DEF = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 9'h000;

    typedef enum logic [1:0] {SBIC_TX_IDLE, SBIC_TX_SEND} sbic_tx_state_t;
    typedef enum logic [2:0] {
        SBIC_RX_IDLE, SBIC_RX_START, SBIC_RX_DATA, SBIC_RX_STOP, SBIC_RX_WAIT
    } sbic_rx_state_t;

    // line format selected by software
    typedef struct packed {
        logic longWord;     // word-length select
        logic parityOn;
        logic parityOdd;
    } sbic_fmt_t;

    // receive flags shown to software
    typedef struct packed {
        logic rxHoldingFull;
        logic framingError;
        logic parityError;
        logic breakSeen;
    } sbic_rx_flags_t;
endpackage

// ---- hdl/sbic_top.sv ----
/*
 * break detect, idle character handling and a small serial transceiver,
 * with a transmit fifo in front of the shifter.
 * assumes control ports come from logic on clk; the receive pin is
 * asynchronous and is synchronised here.
 */
`timescale 1ns/10ps

// ------------------------------------------------------------
// transmit fifo
// ------------------------------------------------------------
module sbic_fifo #(
    parameter int unsigned W = sbic_pkg::DATA_W,
    parameter int unsigned DEPTH = sbic_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk,              // module clock
    input wire logic rst,              // async reset, high
    input wire logic inValid,          // write offered
    output logic inReady,              // room left
    input wire logic [W-1:0] inData,   // word written
    output logic outValid,             // word available
    input wire logic outReady,         // consumer takes word
    output logic [W-1:0] outData       // head word
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
    } sbic_fifo_st_t;

    sbic_fifo_st_t s_q, s_d;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    assign push = inValid & ~s_q.full;
    assign pop = outReady & ~s_q.empty;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        s_d.full = (s_d.cnt == (AW+1)'(DEPTH));
        s_d.empty = (s_d.cnt == '0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // storage has no reset: contents are only read behind the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_q.wp] <= inData;
        end
    end

    assign inReady = ~s_q.full;
    assign outValid = ~s_q.empty;
    assign outData = mem[s_q.rp];
endmodule // sbic_fifo

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module sbic_top #(
    parameter int unsigned BIT_CYCLES = sbic_pkg::BIT_CYCLES_DEF,
    parameter int unsigned FIFO_DEPTH = sbic_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk,                                  // module clock
    input wire logic rst,                                  // async reset, high
    input wire logic txSwitch,                             // transmitter enable
    input wire logic breakDetectEnable,                    // break detection on
    input wire sbic_pkg::sbic_fmt_t fmt,                   // line format
    input wire logic txValid,                              // data write offered
    output logic txReady,                                  // fifo accepts write
    input wire logic [sbic_pkg::DATA_W-1:0] txData,        // data written
    output logic txHoldingVacant,                          // fifo empty
    input wire logic rxPin,                                // serial input pin
    output logic txdOut,                                   // serial output level
    output logic txdOe,                                    // serial output driven
    input wire logic rxFlagClear,                          // read of rx data, clears flags
    output logic [sbic_pkg::DATA_W-1:0] rxData,            // received word
    output sbic_pkg::sbic_rx_flags_t rxFlags               // receive flags
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

    typedef struct packed {
        sbic_pkg::sbic_tx_state_t txState;
        logic [sbic_pkg::FRAME_W-1:0] txBits;
        logic [3:0] txCnt;
        logic [15:0] txDiv;
        logic idleQueued;
        logic preamblePend;
        logic teLast;
        logic txdOut;
        logic txdOe;
        logic rxSync1;
        logic rxSync2;
        sbic_pkg::sbic_rx_state_t rxState;
        logic [15:0] rxDiv;
        logic [3:0] rxCnt;
        logic [sbic_pkg::DATA_W-1:0] rxShift;
        logic rxZero;
        logic [sbic_pkg::DATA_W-1:0] rxData;
        sbic_pkg::sbic_rx_flags_t flags;
    } sbic_st_t;

    sbic_st_t s_q, s_d;
    logic fifoValid, fifoPop;
    logic [sbic_pkg::DATA_W-1:0] fifoData;

    // parity over the data bits below the parity position
    function automatic logic parityOf(input logic [sbic_pkg::DATA_W-1:0] d,
                                      input sbic_pkg::sbic_fmt_t f);
        logic p;
        p = f.longWord ? ^d[7:0] : ^d[6:0];
        return p ^ f.parityOdd;
    endfunction

    function automatic logic [3:0] frameLen(input sbic_pkg::sbic_fmt_t f);
        return f.longWord ? sbic_pkg::FRAME_LEN_LONG : sbic_pkg::FRAME_LEN_SHORT;
    endfunction

    // frame, lsb first: start, data (top data bit replaced by parity), stop
    function automatic logic [sbic_pkg::FRAME_W-1:0] buildFrame(
            input logic [sbic_pkg::DATA_W-1:0] d, input sbic_pkg::sbic_fmt_t f);
        logic [sbic_pkg::DATA_W-1:0] w;
        w = d;
        if (f.parityOn && f.longWord) begin
            w[8] = parityOf(d, f);
        end else if (f.parityOn) begin
            w[7] = parityOf(d, f);
        end
        if (f.longWord) begin
            return {1'b1, w, 1'b0};
        end
        return {2'b11, w[7:0], 1'b0};
    endfunction

    sbic_fifo #(.W(sbic_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(txValid),
        .inReady(txReady),
        .inData(txData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    always_comb begin
        logic teRise;
        logic [3:0] dataLen;
        logic parBit;
        teRise = 1'b0;
        dataLen = 4'h0;
        parBit = 1'b0;
        s_d = s_q;
        fifoPop = 1'b0;

        // ------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------
        teRise = txSwitch & ~s_q.teLast;
        s_d.teLast = txSwitch;
        if (teRise) begin
            if (s_q.txState == sbic_pkg::SBIC_TX_SEND) begin
                s_d.idleQueued = 1'b1;
            end else begin
                s_d.preamblePend = 1'b1;
            end
        end
        unique case (s_q.txState)
            sbic_pkg::SBIC_TX_IDLE: begin
                s_d.txdOut = sbic_pkg::LINE_IDLE;
                // the edge itself starts the idle, so waiting fifo data cannot
                // slip out ahead of the preamble
                if (txSwitch && (teRise || s_q.preamblePend || s_q.idleQueued)) begin
                    s_d.txBits = '1;
                    s_d.txCnt = frameLen(fmt);
                    s_d.txDiv = BIT_LAST;
                    s_d.preamblePend = 1'b0;
                    s_d.idleQueued = 1'b0;
                    s_d.txState = sbic_pkg::SBIC_TX_SEND;
                end else if (txSwitch && fifoValid) begin
                    fifoPop = 1'b1;
                    s_d.txBits = buildFrame(fifoData, fmt);
                    s_d.txdOut = s_d.txBits[0];
                    s_d.txCnt = frameLen(fmt);
                    s_d.txDiv = BIT_LAST;
                    s_d.txState = sbic_pkg::SBIC_TX_SEND;
                end
            end
            sbic_pkg::SBIC_TX_SEND: begin
                if (s_q.txDiv != 16'h0000) begin
                    s_d.txDiv = s_q.txDiv - 16'h0001;
                end else if (s_q.txCnt == 4'h1) begin
                    s_d.txdOut = sbic_pkg::LINE_IDLE;
                    s_d.txState = sbic_pkg::SBIC_TX_IDLE;
                end else begin
                    s_d.txBits = {1'b1, s_q.txBits[sbic_pkg::FRAME_W-1:1]};
                    s_d.txdOut = s_d.txBits[0];
                    s_d.txCnt = s_q.txCnt - 4'h1;
                    s_d.txDiv = BIT_LAST;
                end
            end
            default: begin
                s_d.txState = sbic_pkg::SBIC_TX_IDLE;
            end
        endcase
        s_d.txdOe = txSwitch | (s_d.txState == sbic_pkg::SBIC_TX_SEND);

        // ------------------------------------------------------------
        // receiver
        // ------------------------------------------------------------
        s_d.rxSync1 = rxPin;
        s_d.rxSync2 = s_q.rxSync1;
        dataLen = fmt.longWord ? sbic_pkg::DATA_LEN_LONG : sbic_pkg::DATA_LEN_SHORT;
        parBit = fmt.longWord ? s_q.rxShift[8] : s_q.rxShift[7];
        // a read clears first so a new event in the same cycle wins
        if (rxFlagClear) begin
            s_d.flags = '0;
        end
        if (s_q.rxDiv != 16'h0000) begin
            s_d.rxDiv = s_q.rxDiv - 16'h0001;
        end
        unique case (s_q.rxState)
            sbic_pkg::SBIC_RX_IDLE: begin
                if (!s_q.rxSync2) begin
                    s_d.rxDiv = BIT_HALF;
                    s_d.rxState = sbic_pkg::SBIC_RX_START;
                end
            end
            sbic_pkg::SBIC_RX_START: begin
                if (s_q.rxDiv == 16'h0000) begin
                    s_d.rxDiv = BIT_LAST;
                    s_d.rxCnt = 4'h0;
                    s_d.rxShift = '0;
                    s_d.rxZero = 1'b1;
                    s_d.rxState = s_q.rxSync2 ? sbic_pkg::SBIC_RX_IDLE
                                              : sbic_pkg::SBIC_RX_DATA;
                end
            end
            sbic_pkg::SBIC_RX_DATA: begin
                if (s_q.rxDiv == 16'h0000) begin
                    s_d.rxShift[s_q.rxCnt] = s_q.rxSync2;
                    s_d.rxZero = s_q.rxZero & ~s_q.rxSync2;
                    s_d.rxCnt = s_q.rxCnt + 4'h1;
                    s_d.rxDiv = BIT_LAST;
                    if (s_q.rxCnt == dataLen - 4'h1) begin
                        s_d.rxState = sbic_pkg::SBIC_RX_STOP;
                    end
                end
            end
            sbic_pkg::SBIC_RX_STOP: begin
                if (s_q.rxDiv == 16'h0000) begin
                    s_d.rxState = s_q.rxSync2 ? sbic_pkg::SBIC_RX_IDLE
                                              : sbic_pkg::SBIC_RX_WAIT;
                    if (!s_q.rxSync2 && s_q.rxZero && breakDetectEnable) begin
                        s_d.flags.breakSeen = 1'b1;
                    end else begin
                        s_d.rxData = fmt.longWord ? s_q.rxShift
                                                  : {1'b0, s_q.rxShift[7:0]};
                        s_d.flags.rxHoldingFull = 1'b1;
                        if (!s_q.rxSync2) begin
                            s_d.flags.framingError = 1'b1;
                        end
                        if (fmt.parityOn && (parityOf(s_q.rxShift, fmt) != parBit)) begin
                            s_d.flags.parityError = 1'b1;
                        end
                    end
                end
            end
            sbic_pkg::SBIC_RX_WAIT: begin
                // hold off until the line returns high after a break
                if (s_q.rxSync2) begin
                    s_d.rxState = sbic_pkg::SBIC_RX_IDLE;
                end
            end
            default: begin
                s_d.rxState = sbic_pkg::SBIC_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{txState: sbic_pkg::SBIC_TX_IDLE, txBits: '1, txCnt: 4'h0,
                     txDiv: sbic_pkg::CNT_RST, idleQueued: 1'b0, preamblePend: 1'b0,
                     teLast: 1'b0, txdOut: sbic_pkg::LINE_IDLE, txdOe: 1'b0,
                     rxSync1: sbic_pkg::LINE_IDLE, rxSync2: sbic_pkg::LINE_IDLE,
                     rxState: sbic_pkg::SBIC_RX_IDLE, rxDiv: sbic_pkg::CNT_RST,
                     rxCnt: 4'h0, rxShift: sbic_pkg::DATA_RST, rxZero: 1'b0,
                     rxData: sbic_pkg::DATA_RST, flags: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign txdOut = s_q.txdOut;
    assign txdOe = s_q.txdOe;
    assign rxData = s_q.rxData;
    assign rxFlags = s_q.flags;
    assign txHoldingVacant = ~fifoValid;
endmodule // sbic_top

// ---- verif/sbic_top_asserts.sv ----
/* checker for the break and idle block, bound to sbic_top.
   assumes one clock domain and the async high reset. */
`timescale 1ns/10ps
module sbic_top_asserts #(
    parameter int unsigned BIT_CYCLES = 16
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic txSwitch, // enable
    input wire logic breakDetectEnable, // break on
    input wire sbic_pkg::sbic_fmt_t fmt, // format
    input wire logic txValid, // offer
    input wire logic txReady, // room
    input wire logic [sbic_pkg::DATA_W-1:0] txData, // word
    input wire logic txHoldingVacant, // empty
    input wire logic rxPin, // rx line
    input wire logic txdOut, // tx line
    input wire logic txdOe, // tx driven
    input wire logic rxFlagClear, // clear
    input wire logic [sbic_pkg::DATA_W-1:0] rxData, // rx word
    input wire sbic_pkg::sbic_rx_flags_t rxFlags // flags
);
    // --------------------
    // helpers
    // --------------------
    localparam int unsigned LIM = 11 * BIT_CYCLES + 2;
    logic [15:0] offCnt_q;
    // a frame may finish after the switch drops, but no longer than one long frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offCnt_q <= 16'h0000;
        end else begin
            offCnt_q <= (txdOe && !txSwitch) ? offCnt_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence driveIdle;
        txdOe && txdOut;
    endsequence
    sequence idleOnes;
        txdOut [*8];
    endsequence
    // --------------------
    // properties
    // --------------------
    released_idle_a: assert property (!txdOe |-> txdOut)
        else $error("released line not high");
    enable_preamble_a: assert property (
        $rose(txSwitch) && !txdOe |=> driveIdle ##1 idleOnes)
        else $error("no idle preamble after enable");
    break_quiet_a: assert property (
        $rose(rxFlags.breakSeen) && !$past(rxFlagClear) |->
        $stable(rxFlags.rxHoldingFull) && $stable(rxData))
        else $error("break loaded data");
    break_noerr_a: assert property (
        $rose(rxFlags.breakSeen) |-> !$rose(rxFlags.framingError) && !$rose(rxFlags.parityError))
        else $error("break raised an error");
    mid_break_a: assert property (
        $rose(rxFlags.framingError) |-> rxFlags.rxHoldingFull && !$rose(rxFlags.breakSeen))
        else $error("framing error without full");
    frame_finish_a: assert property (txdOe && !txdOut |=> txdOe)
        else $error("line released mid frame");
    release_bound_a: assert property (offCnt_q <= LIM)
        else $error("line held too long after disable");
    hold_write_a: assert property (txValid && txReady |=> !txHoldingVacant)
        else $error("holding vacant after write");
endmodule // sbic_top_asserts

bind sbic_top sbic_top_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk(clk), .rst(rst),
    .txSwitch(txSwitch), .breakDetectEnable(breakDetectEnable), .fmt(fmt),
    .txValid(txValid), .txReady(txReady), .txData(txData), .txHoldingVacant(txHoldingVacant),
    .rxPin(rxPin), .txdOut(txdOut), .txdOe(txdOe), .rxFlagClear(rxFlagClear),
    .rxData(rxData), .rxFlags(rxFlags));

// ---- verif/sbic_remote_node.sv ----
/* remote serial node: drives the device receive line, catches its frames.
   assumes idle-high lines and BIT_CYCLES clocks per bit. */
`timescale 1ns/10ps
module sbic_remote_node #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk, // clock
    output logic lineOut, // to rx pin
    input wire logic lineIn, // tx level
    input wire logic lineOe, // tx driven
    input wire logic longWord // 11 bit frames
);
    logic [10:0] words[$];
    int starts[$];
    int cycle = 0;
    initial lineOut = 1'b1;
    always @(posedge clk) cycle <= cycle + 1;
    task automatic send_bits(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            lineOut <= bits[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        lineOut <= 1'b1;
    endtask
    // sample mid bit; a released line is never read as a start
    initial begin : catcher
        logic [10:0] w;
        int n;
        forever begin
            @(posedge clk);
            if (lineOe === 1'b1 && lineIn === 1'b0) begin
                starts.push_back(cycle);
                w = 11'h000;
                n = longWord ? 11 : 10;
                repeat (BIT_CYCLES / 2) @(posedge clk);
                for (int i = 0; i < n; i++) begin
                    w[i] = lineIn;
                    if (i < n - 1) repeat (BIT_CYCLES) @(posedge clk);
                end
                words.push_back(w);
            end
        end
    end
endmodule // sbic_remote_node

// ---- verif/sbic_top_tb.sv ----
/* self-checking bench for sbic_top with a remote node on the line.
   assumes a short bit time of 4 clocks. */
`timescale 1ns/10ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t got %0h exp %0h", $time, (g), (e)); end end
module sbic_top_tb;
    localparam int BC = 4;
    logic clk, rst, txSwitch, breakDetectEnable, txValid, rxFlagClear;
    logic txReady, txHoldingVacant, rxPin, txdOut, txdOe;
    logic [sbic_pkg::DATA_W-1:0] txData, rxData, w, lastData;
    sbic_pkg::sbic_fmt_t fmt;
    sbic_pkg::sbic_rx_flags_t rxFlags, expF;
    sbic_pkg::sbic_fmt_t fmtTab [4] = '{3'h0, 3'h4, 3'h3, 3'h6};
    logic [8:0] q[$];
    logic [10:0] bits;
    logic [31:0] seed = 32'h0000d87e;
    int errors = 0, samplesChecked = 0, cycles = 0, n0, t0, L;
    sbic_top #(.BIT_CYCLES(BC), .FIFO_DEPTH(16)) u_dut (.clk(clk), .rst(rst),
        .txSwitch(txSwitch), .breakDetectEnable(breakDetectEnable), .fmt(fmt),
        .txValid(txValid), .txReady(txReady), .txData(txData),
        .txHoldingVacant(txHoldingVacant), .rxPin(rxPin), .txdOut(txdOut), .txdOe(txdOe),
        .rxFlagClear(rxFlagClear), .rxData(rxData), .rxFlags(rxFlags));
    sbic_remote_node #(.BIT_CYCLES(BC)) u_node (.clk(clk), .lineOut(rxPin),
        .lineIn(txdOut), .lineOe(txdOe), .longWord(fmt.longWord));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end
    // --------------------
    // helpers
    // --------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // parity takes the top data bit, so frame length never changes
    function automatic logic [10:0] frame_of(logic [8:0] d, sbic_pkg::sbic_fmt_t f);
        logic [8:0] v;
        v = d;
        if (f.parityOn && f.longWord) v[8] = ^d[7:0] ^ f.parityOdd;
        if (f.parityOn && !f.longWord) v[7] = ^d[6:0] ^ f.parityOdd;
        return f.longWord ? {1'b1, v, 1'b0} : {2'h1, v[7:0], 1'b0};
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic put(logic [8:0] d);
        txValid <= 1'b1;
        txData <= d;
        @(posedge clk);
        txValid <= 1'b0;
    endtask
    task automatic wait_starts(int n);
        int k;
        k = 0;
        while (u_node.starts.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        `CHK(u_node.starts.size() >= n, 1'b1)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // --------------------
    // sequence
    // --------------------
    initial begin
        {txSwitch, breakDetectEnable, txValid, rxFlagClear} = 4'h0;
        fmt = 3'h0;
        txData = 9'h000;
        rst = 1'b1;
        tick(5);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({txdOut, txdOe, txReady, txHoldingVacant, rxData, rxFlags}, 17'h16000)
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            fmt <= fmtTab[k];
            txSwitch <= 1'b0;
            tick(30 * BC);
            n0 = u_node.starts.size();
            q.delete();
            txValid <= 1'b1;
            for (int i = 0; i < 17; i++) begin
                txData <= 9'(rnd());
                @(posedge clk);
                if (txReady === 1'b1) q.push_back(txData);
            end
            txValid <= 1'b0;
            tick(22 * BC);
            `CHK(q.size(), 16)
            `CHK(u_node.starts.size(), n0)
            L = fmt.longWord ? 11 : 10;
            txSwitch <= 1'b1;
            t0 = u_node.cycle;
            wait_starts(n0 + 16);
            tick(12 * BC);
            `CHK((u_node.starts[n0] - t0 >= L * BC) && (u_node.starts[n0] - t0 <= L * BC + 6), 1'b1)
            for (int i = 0; i < 16; i++) `CHK(u_node.words[n0 + i], frame_of(q[i], fmt))
            `CHK(txHoldingVacant, 1'b1)
        end
        $display("test preamble and formats done");
        n0 = u_node.starts.size();
        w = 9'(rnd());
        put(9'(rnd()));
        wait_starts(n0 + 1);
        tick(2 * BC);
        txSwitch <= 1'b0;
        @(posedge clk);
        txSwitch <= 1'b1;
        put(w);
        wait_starts(n0 + 2);
        tick(L * BC + 4);
        t0 = u_node.starts[n0 + 1] - u_node.starts[n0];
        `CHK((t0 >= 2 * L * BC) && (t0 <= 2 * L * BC + 6), 1'b1)
        `CHK(u_node.words[n0 + 1], frame_of(w, fmt))
        put(w);
        wait_starts(n0 + 3);
        tick(BC);
        txSwitch <= 1'b0;
        tick(L * BC + 4);
        `CHK(u_node.words[n0 + 2], frame_of(w, fmt))
        `CHK({txdOe, txdOut}, 2'h1)
        put(~w);
        tick(2 * L * BC);
        `CHK({u_node.starts.size() == n0 + 3, txHoldingVacant}, 2'h2)
        txSwitch <= 1'b1;
        wait_starts(n0 + 4);
        tick(L * BC + 4);
        `CHK(u_node.words[n0 + 3], frame_of(~w, fmt))
        $display("test idle queue and release done");
        for (int c = 0; c < 5; c++) begin
            w = 9'(rnd());
            // a mid-frame break needs one high data bit, or it reads as a clean break
            w[0] = w[0] | (c == 2) | (c == 3);
            fmt <= (c == 1) ? 3'h3 : (c == 3) ? 3'h2 : (c == 4) ? 3'h4 : 3'h0;
            breakDetectEnable <= (c != 4);
            // no clear before the clean break: the full flag of the frame before must survive
            rxFlagClear <= (c != 1);
            @(posedge clk);
            rxFlagClear <= 1'b0;
            bits = (c == 0) ? {2'h1, w[7:0], 1'b0} : (c == 2 || c == 3) ? {6'h00, w[3:0], 1'b0} : 11'h000;
            u_node.send_bits(bits, (c == 0) ? 10 : 11);
            tick(BC);
            expF = (c == 0) ? 4'h8 : (c == 1) ? 4'h9 : (c == 4) ? 4'hc : {3'h6, 1'b0};
            if (c == 3) expF.parityError = ^w[3:0];
            if (c != 1) lastData = {1'b0, bits[8:1]};
            `CHK(rxFlags, expF)
            `CHK(rxData, lastData)
        end
        $display("test receive breaks done");
        report_and_stop();
    end
endmodule // sbic_top_tb
